// [rtl/main_tlb_test_access.sv]
// Main TLB debug and test access path with data RAM port
module main_tlb_test_access
    import tlb_test_pkg::*;
#(
    parameter int INDEX_W = IDX_W
)
(
    input  wire logic                 clk_sys,
    input  wire logic                 sys_rst,
    input  cp_cmd_t                   cp_cmd,
    output logic                      cp_busy,
    output logic                      cp_done,
    output logic       [31:0]         cp_rdata,
    output logic       [INDEX_W-1:0]  tlb_ram_index_bus,
    output logic                      tlb_ram_chip_select,
    output logic       [LANES-1:0]    tlb_ram_lane_enables,
    output logic       [RAM_W-1:0]    tlb_ram_write_bus,
    output logic                      tlb_ram_output_enable,
    input  wire logic  [RAM_W-1:0]    tlb_ram_read_bus
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RD_WAIT,
        ST_RD_CAPTURE
    } state_t;

    localparam int DEPTH = 2 ** INDEX_W;

    // Matches a main TLB test operation on the given CRm
    function automatic logic test_hit(
        input cp_cmd_t    c,
        input logic [3:0] crm
    );
        logic op1_ok;
        op1_ok = (c.op1 == OP1_TEST_A) || (c.op1 == OP1_TEST_B);
        return c.valid && (c.crn == CRN_TEST) && op1_ok
            && (c.op2 == OP2_MAIN) && (c.crm == crm);
    endfunction

    state_t              state_reg;
    state_t              state_next;
    logic [31:0]         sel_reg;
    logic [31:0]         sel_next;
    logic [31:0]         tag_reg;
    logic [31:0]         tag_next;
    logic [31:0]         phys_reg;
    logic [31:0]         phys_next;
    logic                rd_phys_reg;
    logic                rd_phys_next;
    logic                done_reg;
    logic                done_next;
    logic [31:0]         rdata_reg;
    logic [31:0]         rdata_next;
    logic                busy_reg;
    logic                busy_next;
    logic                oe_reg;
    ram_req_t            req_reg;
    ram_req_t            req_next;
    logic [DEPTH-1:0]    valid_way0_reg;
    logic [DEPTH-1:0]    valid_way1_reg;

    wire logic           take;
    wire logic           hit_select;
    wire logic           sel_wr;
    wire logic           sel_rd;
    wire logic           tag_wr;
    wire logic           phys_wr;
    wire logic           xfer;
    wire logic           tag_rd;
    wire logic           phys_rd;
    wire logic           start_read;
    wire logic           sel_way;
    wire logic [INDEX_W-1:0] sel_index;
    wire logic           entry_valid;
    wire logic [31:0]    sel_masked;
    tlb_half_t           staged_half;
    tlb_half_t           read_half;
    logic [31:0]         read_tag_word;
    logic [31:0]         read_phys_word;
    wire logic [3:0]     way_lanes;

    // Command decode
    assign take       = cp_cmd.valid && (state_reg == ST_IDLE);
    assign hit_select = (cp_cmd.crn == CRN_TEST)
                     && (cp_cmd.op1 == OP1_SELECT)
                     && (cp_cmd.crm == CRM_SELECT)
                     && (cp_cmd.op2 == OP2_MAIN);
    assign sel_wr     = take && cp_cmd.write && hit_select;
    assign sel_rd     = take && !cp_cmd.write && hit_select;
    assign tag_wr     = take && cp_cmd.write
                     && test_hit(cp_cmd, CRM_TAG_WR);
    assign phys_wr    = take && cp_cmd.write
                     && test_hit(cp_cmd, CRM_PHYS_WR);
    assign xfer       = take && cp_cmd.write
                     && test_hit(cp_cmd, CRM_XFER);
    assign tag_rd     = take && !cp_cmd.write
                     && test_hit(cp_cmd, CRM_TAG_RD);
    assign phys_rd    = take && !cp_cmd.write
                     && test_hit(cp_cmd, CRM_PHYS_RD);
    assign start_read = tag_rd || phys_rd;

    assign sel_way    = sel_reg[SEL_WAY_BIT];
    assign sel_index  = sel_reg[SEL_IDX_LSB +: INDEX_W];
    assign sel_masked = sel_reg & SEL_KEEP_MASK;

    assign entry_valid = sel_way ? valid_way1_reg[sel_index]
                                 : valid_way0_reg[sel_index];

    assign way_lanes  = sel_way ? LANES_WAY1 : LANES_WAY0;

    tlb_entry_pack u_pack (
        .tag_word  (tag_reg),
        .phys_word (phys_reg),
        .half      (staged_half)
    );

    assign read_half = sel_way ? tlb_half_t'(tlb_ram_read_bus[RAM_W-1:HALF_W])
                               : tlb_half_t'(tlb_ram_read_bus[HALF_W-1:0]);

    tlb_entry_unpack u_unpack (
        .half      (read_half),
        .valid     (entry_valid),
        .tag_word  (read_tag_word),
        .phys_word (read_phys_word)
    );

    // Next state and outputs
    always_comb begin
        state_next   = state_reg;
        sel_next     = sel_reg;
        tag_next     = tag_reg;
        phys_next    = phys_reg;
        rd_phys_next = rd_phys_reg;
        done_next    = 1'b0;
        rdata_next   = rdata_reg;
        busy_next    = 1'b0;
        req_next.cs    = 1'b0;
        req_next.lanes = LANES_NONE;
        req_next.index = req_reg.index;
        req_next.wdata = req_reg.wdata;
        case (state_reg)
            ST_IDLE: begin
                if (take) begin
                    done_next  = !start_read;
                    rdata_next = WORD_RST;
                end
                if (sel_wr) begin
                    sel_next = cp_cmd.wdata & SEL_KEEP_MASK;
                end
                if (sel_rd) begin
                    rdata_next = sel_masked;
                end
                if (tag_wr) begin
                    tag_next = cp_cmd.wdata & TAG_KEEP_MASK;
                end
                if (phys_wr) begin
                    phys_next = cp_cmd.wdata & PHYS_KEEP_MASK;
                end
                if (xfer) begin
                    req_next.cs    = 1'b1;
                    req_next.lanes = way_lanes;
                    req_next.index = sel_index;
                    req_next.wdata = {staged_half, staged_half};
                end
                if (start_read) begin
                    req_next.cs    = 1'b1;
                    req_next.lanes = LANES_NONE;
                    req_next.index = sel_index;
                    rd_phys_next   = phys_rd;
                    busy_next      = 1'b1;
                    state_next     = ST_RD_WAIT;
                end
            end
            ST_RD_WAIT: begin
                busy_next  = 1'b1;
                state_next = ST_RD_CAPTURE;
            end
            ST_RD_CAPTURE: begin
                rdata_next = rd_phys_reg ? read_phys_word
                                         : read_tag_word;
                done_next  = 1'b1;
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Control and staging registers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg   <= ST_IDLE;
            sel_reg     <= WORD_RST;
            tag_reg     <= WORD_RST;
            phys_reg    <= WORD_RST;
            rd_phys_reg <= 1'b0;
            done_reg    <= 1'b0;
            rdata_reg   <= WORD_RST;
            busy_reg    <= 1'b0;
        end else begin
            state_reg   <= state_next;
            sel_reg     <= sel_next;
            tag_reg     <= tag_next;
            phys_reg    <= phys_next;
            rd_phys_reg <= rd_phys_next;
            done_reg    <= done_next;
            rdata_reg   <= rdata_next;
            busy_reg    <= busy_next;
        end
    end

    // RAM request registers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            req_reg <= '0;
            oe_reg  <= 1'b1;
        end else begin
            req_reg <= req_next;
            oe_reg  <= 1'b1;
        end
    end

    // Valid bits per entry, kept beside the RAM
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            valid_way0_reg <= '0;
            valid_way1_reg <= '0;
        end else if (xfer) begin
            if (sel_way) begin
                valid_way1_reg[sel_index] <= tag_reg[VALID_BIT];
            end else begin
                valid_way0_reg[sel_index] <= tag_reg[VALID_BIT];
            end
        end
    end

    assign cp_busy               = busy_reg;
    assign cp_done               = done_reg;
    assign cp_rdata              = rdata_reg;
    assign tlb_ram_chip_select   = req_reg.cs;
    assign tlb_ram_lane_enables  = req_reg.lanes;
    assign tlb_ram_index_bus     = req_reg.index;
    assign tlb_ram_write_bus     = req_reg.wdata;
    assign tlb_ram_output_enable = oe_reg;

endmodule // main_tlb_test_access

// [rtl/tlb_test_pkg.sv]
// Constants and carrier types for main TLB test access
package tlb_test_pkg;

    localparam logic [3:0]   CRN_TEST       = 4'hF;
    localparam logic [3:0]   CRM_SELECT     = 4'h1;
    localparam logic [3:0]   CRM_TAG_RD     = 4'h2;
    localparam logic [3:0]   CRM_TAG_WR     = 4'h3;
    localparam logic [3:0]   CRM_PHYS_RD    = 4'h4;
    localparam logic [3:0]   CRM_PHYS_WR    = 4'h5;
    localparam logic [3:0]   CRM_XFER       = 4'h7;
    localparam logic [2:0]   OP1_SELECT     = 3'h0;
    localparam logic [2:0]   OP1_TEST_A     = 3'h4;
    localparam logic [2:0]   OP1_TEST_B     = 3'h5;
    localparam logic [2:0]   OP2_MAIN       = 3'h0;

    localparam int           SEL_WAY_BIT    = 31;
    localparam int           SEL_IDX_LSB    = 10;
    localparam int           IDX_W          = 5;
    localparam int           TAG_LSB        = 10;
    localparam int           VALID_BIT      = 4;
    localparam int           SIZE_LSB       = 0;
    localparam int           PHYS_ADDR_LSB  = 10;
    localparam int           DOMAIN_LSB     = 4;
    localparam int           PERM_LSB       = 2;
    localparam int           CACHE_BIT      = 1;
    localparam int           BUFF_BIT       = 0;

    localparam logic [31:0]  SEL_KEEP_MASK  = 32'h80007C00;
    localparam logic [31:0]  TAG_KEEP_MASK  = 32'hFFFFFC1F;
    localparam logic [31:0]  PHYS_KEEP_MASK = 32'hFFFFFCFF;
    localparam logic [31:0]  WORD_RST       = 32'h00000000;

    localparam logic [3:0]   SIZE_1MB       = 4'hB;
    localparam logic [3:0]   SIZE_64KB      = 4'h7;
    localparam logic [3:0]   SIZE_16KB      = 4'h5;
    localparam logic [3:0]   SIZE_4KB       = 4'h3;
    localparam logic [3:0]   SIZE_1KB       = 4'h1;
    localparam logic [1:0]   PERM_NONE      = 2'h0;
    localparam logic [1:0]   PERM_PRIV      = 2'h1;
    localparam logic [1:0]   PERM_USER_RO   = 2'h2;
    localparam logic [1:0]   PERM_FULL      = 2'h3;

    localparam int           RAM_W          = 112;
    localparam int           HALF_W         = 56;
    localparam int           LANES          = 4;
    localparam logic [3:0]   LANES_WAY0     = 4'h3;
    localparam logic [3:0]   LANES_WAY1     = 4'hC;
    localparam logic [3:0]   LANES_NONE     = 4'h0;

    typedef struct packed {
        logic         valid;
        logic         write;
        logic [2:0]   op1;
        logic [3:0]   crn;
        logic [3:0]   crm;
        logic [2:0]   op2;
        logic [31:0]  wdata;
    } cp_cmd_t;

    typedef struct packed {
        logic [21:0]  tag;
        logic [3:0]   size;
        logic [21:0]  phys_addr;
        logic [3:0]   domain;
        logic [1:0]   perm;
        logic         cachable;
        logic         bufferable;
    } tlb_half_t;

    typedef struct packed {
        logic               cs;
        logic [LANES-1:0]   lanes;
        logic [IDX_W-1:0]   index;
        logic [RAM_W-1:0]   wdata;
    } ram_req_t;

endpackage

// [rtl/tlb_entry_pack.sv]
// Packs the staging words into one RAM way image
module tlb_entry_pack
    import tlb_test_pkg::*;
(
    input  wire logic [31:0] tag_word,
    input  wire logic [31:0] phys_word,
    output tlb_half_t        half
);
    assign half.tag        = tag_word[31:TAG_LSB];
    assign half.size       = tag_word[SIZE_LSB +: 4];
    assign half.phys_addr  = phys_word[31:PHYS_ADDR_LSB];
    assign half.domain     = phys_word[DOMAIN_LSB +: 4];
    assign half.perm       = phys_word[PERM_LSB +: 2];
    assign half.cachable   = phys_word[CACHE_BIT];
    assign half.bufferable = phys_word[BUFF_BIT];
endmodule // tlb_entry_pack

// [rtl/tlb_entry_unpack.sv]
// Rebuilds tag and physical words from one RAM way image
module tlb_entry_unpack
    import tlb_test_pkg::*;
(
    input  tlb_half_t         half,
    input  wire logic         valid,
    output logic      [31:0]  tag_word,
    output logic      [31:0]  phys_word
);
    assign tag_word  = {half.tag, 5'h00, valid, half.size};
    assign phys_word = {half.phys_addr, 2'h0, half.domain, half.perm,
                        half.cachable, half.bufferable};
endmodule // tlb_entry_unpack

// [testbench/test_access_chk.sv]
// Port checker for the main TLB test access block
module test_access_chk
    import tlb_test_pkg::*;
#(
    parameter int INDEX_W = IDX_W
)
(
    input  wire logic                clk_sys,
    input  wire logic                sys_rst,
    input  cp_cmd_t                  cp_cmd,
    input  wire logic                cp_busy,
    input  wire logic                cp_done,
    input  wire logic [31:0]         cp_rdata,
    input  wire logic [INDEX_W-1:0]  tlb_ram_index_bus,
    input  wire logic                tlb_ram_chip_select,
    input  wire logic [LANES-1:0]    tlb_ram_lane_enables,
    input  wire logic [RAM_W-1:0]    tlb_ram_write_bus,
    input  wire logic                tlb_ram_output_enable,
    input  wire logic [RAM_W-1:0]    tlb_ram_read_bus
);
    logic        busy_d;
    logic [31:0] sel_q, tag_q, phys_q;
    wire hi = cp_cmd.crn == CRN_TEST && cp_cmd.op2 == OP2_MAIN;
    wire ts = hi && (cp_cmd.op1 == OP1_TEST_A || cp_cmd.op1 == OP1_TEST_B);
    wire sh = hi && cp_cmd.op1 == OP1_SELECT && cp_cmd.crm == CRM_SELECT;
    wire tk = cp_cmd.valid && !cp_busy;
    wire wt = tk && cp_cmd.write;
    wire xf = wt && ts && cp_cmd.crm == CRM_XFER;
    wire rr = tk && !cp_cmd.write && ts
              && (cp_cmd.crm == CRM_TAG_RD || cp_cmd.crm == CRM_PHYS_RD);
    wire sr = tk && !cp_cmd.write && sh;
    wire [55:0] img = {tag_q[31:10], tag_q[3:0], phys_q[31:10], phys_q[7:0]};

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            {busy_d, sel_q, tag_q, phys_q} <= '0;
        end else begin
            busy_d <= cp_busy;
            if (wt && sh) sel_q <= cp_cmd.wdata & 32'h80007C00;
            if (wt && ts && cp_cmd.crm == CRM_TAG_WR) tag_q <= cp_cmd.wdata;
            if (wt && ts && cp_cmd.crm == CRM_PHYS_WR) phys_q <= cp_cmd.wdata;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_read;
        tlb_ram_chip_select && tlb_ram_lane_enables == LANES_NONE && cp_busy
        ##1 !tlb_ram_chip_select && cp_busy ##1 cp_done && !cp_busy;
    endsequence

    property p_read; rr |=> s_read; endproperty
    a_read: assert property (p_read) else $error("read walk wrong");
    property p_oe; tlb_ram_output_enable; endproperty
    a_oe: assert property (p_oe) else $error("output enable low");
    property p_idle; !tlb_ram_chip_select |-> !tlb_ram_lane_enables;
    endproperty
    a_idle: assert property (p_idle) else $error("lanes without cs");
    property p_repl; tlb_ram_chip_select && |tlb_ram_lane_enables
        |-> tlb_ram_write_bus[111:56] == tlb_ram_write_bus[55:0]; endproperty
    a_repl: assert property (p_repl) else $error("halves differ");
    property p_lanes; xf |=> tlb_ram_chip_select
        && tlb_ram_lane_enables == (sel_q[31] ? 4'hC : 4'h3); endproperty
    a_lanes: assert property (p_lanes) else $error("lanes wrong");
    property p_index; xf |=> tlb_ram_index_bus == sel_q[14:10]; endproperty
    a_index: assert property (p_index) else $error("index wrong");
    property p_img; xf |=> tlb_ram_write_bus[55:0] == img; endproperty
    a_img: assert property (p_img) else $error("image wrong");
    property p_done; wt |=> cp_done; endproperty
    a_done: assert property (p_done) else $error("no done");
    property p_selrd; sr |=> cp_done && cp_rdata == sel_q; endproperty
    a_selrd: assert property (p_selrd) else $error("select read");
endmodule // test_access_chk

bind main_tlb_test_access test_access_chk #(.INDEX_W(INDEX_W)) u_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .cp_cmd(cp_cmd),
    .cp_busy(cp_busy), .cp_done(cp_done), .cp_rdata(cp_rdata),
    .tlb_ram_index_bus(tlb_ram_index_bus),
    .tlb_ram_chip_select(tlb_ram_chip_select),
    .tlb_ram_lane_enables(tlb_ram_lane_enables),
    .tlb_ram_write_bus(tlb_ram_write_bus),
    .tlb_ram_output_enable(tlb_ram_output_enable),
    .tlb_ram_read_bus(tlb_ram_read_bus));

// [testbench/ram_model.sv]
// Behavioural data RAM on the far side of the block
module ram_model
    import tlb_test_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic [IDX_W-1:0]  index,
    input  wire logic              cs,
    input  wire logic [LANES-1:0]  lanes,
    input  wire logic [RAM_W-1:0]  wdata,
    output logic      [RAM_W-1:0]  rdata
);
    logic [RAM_W-1:0] mem [2**IDX_W];
    logic [RAM_W-1:0] mask;
    assign mask = {{26{lanes[3]}}, {29{lanes[2]}}, 1'b0,
                   {26{lanes[1]}}, {30{lanes[0]}}};
    initial begin
        foreach (mem[i]) mem[i] = '0;
        rdata = '0;
    end
    always @(posedge clk_sys) begin
        if (cs) begin
            mem[index] <= (mem[index] & ~mask) | (wdata & mask);
            rdata <= mem[index];
        end else begin
            rdata <= ~rdata;
        end
    end
endmodule // ram_model

// [testbench/tb_main_tlb_test_access.sv]
// Self-checking bench for the main TLB test access block
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_main_tlb_test_access
    import tlb_test_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic              clk_sys = 1'b0;
    logic              sys_rst = 1'b1;
    cp_cmd_t           cmd = '0;
    logic              busy, done, ram_cs, ram_oe;
    logic [31:0]       rdata, got;
    logic [4:0]        ram_idx, e_idx;
    logic [3:0]        ram_lanes, e_lanes;
    logic [111:0]      ram_wd, ram_rd;
    logic [55:0]       e_half;
    logic [31:0]       e_tag [2][32];
    logic [31:0]       e_phys [2][32];
    logic [3:0]        sizes [5] = '{4'hB, 4'h7, 4'h5, 4'h3, 4'h1};
    int                n_fail = 0;
    int                checks = 0;
    int                seed = 23;

    always #12.5 clk_sys = ~clk_sys;

    main_tlb_test_access #(.INDEX_W(5)) u_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .cp_cmd(cmd), .cp_busy(busy),
        .cp_done(done), .cp_rdata(rdata), .tlb_ram_index_bus(ram_idx),
        .tlb_ram_chip_select(ram_cs), .tlb_ram_lane_enables(ram_lanes),
        .tlb_ram_write_bus(ram_wd), .tlb_ram_output_enable(ram_oe),
        .tlb_ram_read_bus(ram_rd));
    ram_model u_ram (.clk_sys(clk_sys), .index(ram_idx), .cs(ram_cs),
        .lanes(ram_lanes), .wdata(ram_wd), .rdata(ram_rd));

    task automatic finish_test;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic op(input logic wr, input logic [2:0] o1,
                      input logic [3:0] crm, input logic [31:0] wd,
                      input int lat);
        int n;
        @(posedge clk_sys);
        cmd <= '{1'b1, wr, o1, CRN_TEST, crm, OP2_MAIN, wd};
        @(posedge clk_sys);
        cmd.valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
            if (n == 1 && wr && crm == CRM_XFER) begin
                `CHK({ram_cs, ram_lanes, ram_idx}, {1'b1, e_lanes, e_idx})
                `CHK(ram_wd, {e_half, e_half})
            end
        end while (!done && n < 8);
        `CHK(n, lat)
        got = rdata;
    endtask

    initial begin
        #400000;
        n_fail++;
        finish_test;
    end

    initial begin
        logic        w;
        logic [4:0]  idx;
        logic [2:0]  o1;
        logic [31:0] s, t, p;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        op(1'b0, OP1_SELECT, CRM_SELECT, 32'h0, 1);
        `CHK(got, 32'h0)
        for (int i = 0; i < 24; i++) begin
            w = i[0];
            o1 = i[1] ? OP1_TEST_B : OP1_TEST_A;
            if (!w) begin
                idx = (i == 0) ? 5'h00
                    : (i == 2) ? 5'h1F : 5'($random(seed));
            end
            s = {w, 16'($random(seed)), idx, 10'($random(seed))};
            t = $random(seed);
            t[3:0] = sizes[i % 5];
            p = $random(seed);
            p[7:2] = {4'(i), 2'(i)};
            op(1'b1, OP1_SELECT, CRM_SELECT, s, 1);
            op(1'b0, OP1_SELECT, CRM_SELECT, 32'h0, 1);
            `CHK(got, {s[31], 16'h0, s[14:10], 10'h0})
            e_lanes = w ? 4'hC : 4'h3;
            e_idx = idx;
            e_half = {t[31:10], t[3:0], p[31:10], p[7:0]};
            op(1'b1, o1, CRM_TAG_WR, t, 1);
            op(1'b1, o1, CRM_PHYS_WR, p, 1);
            op(1'b1, o1, CRM_XFER, 32'h0, 1);
            e_tag[w][idx] = {t[31:10], 5'h0, t[4:0]};
            e_phys[w][idx] = {p[31:10], 2'h0, p[7:1], p[0] & !w};
            if (w) begin
                for (int v = 0; v < 2; v++) begin
                    op(1'b1, OP1_SELECT, CRM_SELECT,
                       {v[0], 16'h0, idx, 10'h0}, 1);
                    op(1'b0, o1, CRM_TAG_RD, 32'h0, 3);
                    `CHK(got, e_tag[v][idx])
                    op(1'b0, o1, CRM_PHYS_RD, 32'h0, 3);
                    `CHK(got, e_phys[v][idx])
                end
            end
        end
        `CHK(ram_oe, 1'b1)
        finish_test;
    end
endmodule // tb_main_tlb_test_access
